// ===== src/ptr_table_read.sv
// Table-read sequencer: byte pointer, program memory fetch, latch
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_table_read (
   input wire logic clk,
   input wire logic nrst,
   input wire logic table_read_instr,
   input wire logic table_read_post_inc,
   input wire logic ptr_upper_wr,
   input wire logic ptr_high_wr,
   input wire logic ptr_low_wr,
   input wire logic [`PTR_BYTE_W-1:0] ptr_wr_data,
   output logic [`PTR_WADDR_W-1:0] pm_word_addr,
   output logic pm_rd,
   input wire logic [`PTR_WORD_W-1:0] pm_rd_data,
   output logic [`PTR_PTR_W-1:0] table_byte_pointer,
   output logic [`PTR_BYTE_W-1:0] table_latch,
   output logic busy,
   output logic done
);
   import ptr_pkg::*;
   ptr_state_e state_q;
   ptr_addr_t ptr_q;
   logic inc_q;
   logic rd_q;
   logic done_q;
   logic busy_q;
   ptr_byte_t latch_w;
   ptr_mem_if mif ();

   // Two-cycle read: fetch strobe and word capture in PTR_FETCH, then the done pulse in PTR_DONE
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= PTR_IDLE;
         inc_q <= 1'b0;
      end else begin
         unique case (state_q)
            PTR_IDLE: begin
               if (table_read_instr || table_read_post_inc) begin
                  state_q <= PTR_FETCH; // [RULE1]
                  inc_q <= table_read_post_inc;
               end
            end
            PTR_FETCH: state_q <= PTR_DONE;
            PTR_DONE: state_q <= PTR_IDLE;
         endcase
      end
   end

   // Pointer: software loads bytes while idle; step lands on the same edge as the latch fill
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= `PTR_PTR_RST;
      end else if (state_q == PTR_FETCH && inc_q) begin
         ptr_q <= ptr_addr_t'(ptr_q + `PTR_PTR_STEP); // Latch takes old byte this edge [RULE5] [RULE8]
      end else if (state_q == PTR_IDLE) begin
         // Software sets the base byte address before reading [RULE3]
         if (ptr_upper_wr) ptr_q[`PTR_PTR_W-1:`PTR_UPPER_LSB] <= ptr_wr_data[`PTR_UPPER_W-1:0];
         if (ptr_high_wr) ptr_q[`PTR_UPPER_LSB-1:`PTR_HIGH_LSB] <= ptr_wr_data;
         if (ptr_low_wr) ptr_q[`PTR_HIGH_LSB-1:0] <= ptr_wr_data;
      end
   end

   // Read strobe and completion pulse, registered for clean outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         rd_q <= (state_q == PTR_IDLE) && (table_read_instr || table_read_post_inc);
         done_q <= (state_q == PTR_FETCH);
         // Busy mirrors the next state, so the pin comes from a flop
         busy_q <= (state_q == PTR_IDLE) ? (table_read_instr || table_read_post_inc) : (state_q == PTR_FETCH);
      end
   end

   // Word address drops bit 0: a byte pair shares one word [RULE6]
   assign pm_word_addr = ptr_q[`PTR_PTR_W-1:1];
   assign pm_rd = rd_q;
   assign mif.word = pm_rd_data;
   assign mif.sel_high = ptr_q[0];
   assign mif.take = (state_q == PTR_FETCH);

   ptr_byte_sel u_sel (
      .clk(clk),
      .nrst(nrst),
      .mif(mif),
      .latch_q(latch_w)
   );

   assign table_byte_pointer = ptr_q;
   assign table_latch = latch_w;
   assign busy = busy_q;
   assign done = done_q;
endmodule : ptr_table_read

// ===== common/ptr_params.svh
// Constants for the program memory table-read block
// Functional notes
// RULE1: A table read fetches program memory data so the core can move it into data RAM.
// RULE2: Each table read moves exactly one byte, never a whole word.
// RULE3: The table pointer holds a byte address in program space, not a word address.
// RULE4: A table read loads the byte addressed by the pointer into the table latch.
// RULE5: The pointer may step automatically as part of a table read, ready for the next one.
// RULE6: Program memory is an array of words; two consecutive byte addresses share one word.
// RULE7: The pointer's least significant bit picks the high or low byte of the word.
// RULE8: The post-increment read first fills the latch, then advances the pointer by one byte.
// RULE9: Software loads the upper, high and low pointer bytes before the first read of a word.
// RULE10: The latch keeps its byte until the next table read completes.
`ifndef PTR_PARAMS_SVH
`define PTR_PARAMS_SVH
`define PTR_PTR_W 21
`define PTR_WADDR_W 20
`define PTR_WORD_W 16
`define PTR_BYTE_W 8
`define PTR_UPPER_W 5
`define PTR_UPPER_LSB 16
`define PTR_HIGH_LSB 8
`define PTR_PTR_RST 21'h000000
`define PTR_LAT_RST 8'h00
`define PTR_PTR_STEP 21'h000001
`define PTR_WORD_RST 16'h0000
`endif

// ===== common/ptr_pkg.sv
// Types for the program memory table-read block
`include "ptr_params.svh"
package ptr_pkg;
   typedef logic [`PTR_PTR_W-1:0] ptr_addr_t;
   typedef logic [`PTR_WADDR_W-1:0] ptr_waddr_t;
   typedef logic [`PTR_WORD_W-1:0] ptr_word_t;
   typedef logic [`PTR_BYTE_W-1:0] ptr_byte_t;
   typedef enum logic [1:0] {PTR_IDLE, PTR_FETCH, PTR_DONE} ptr_state_e;
endpackage : ptr_pkg

// ===== common/ptr_mem_if.sv
// Word fetch bundle between the sequencer and byte selector
`timescale 1ns/1ps
interface ptr_mem_if;
   import ptr_pkg::*;
   ptr_word_t word;
   logic sel_high;
   logic take;
   modport seq (output word, output sel_high, output take);
   modport sel (input word, input sel_high, input take);
endinterface : ptr_mem_if

// ===== src/ptr_byte_sel.sv
// Byte selector and table latch
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_byte_sel (
   input wire logic clk,
   input wire logic nrst,
   ptr_mem_if.sel mif,
   output ptr_pkg::ptr_byte_t latch_q
);
   import ptr_pkg::*;
   ptr_byte_t latch_d;

   // Only one byte of the word ever reaches the latch
   always_comb begin
      latch_d = latch_q; // Hold between reads [RULE10]
      if (mif.take) begin
         latch_d = mif.sel_high ? mif.word[`PTR_WORD_W-1:`PTR_BYTE_W] : mif.word[`PTR_BYTE_W-1:0]; // [RULE7] [RULE2]
      end
   end

   // Latch register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch_q <= `PTR_LAT_RST;
      end else begin
         latch_q <= latch_d; // [RULE4]
      end
   end
endmodule : ptr_byte_sel

// ===== bench/ptr_tr_monitor.sv
// Port checker for the table-read block
`timescale 1ns/1ps
module ptr_tr_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic table_read_instr,
   input wire logic table_read_post_inc,
   input wire logic [19:0] pm_word_addr,
   input wire logic pm_rd,
   input wire logic [15:0] pm_rd_data,
   input wire logic [20:0] table_byte_pointer,
   input wire logic [7:0] table_latch,
   input wire logic busy,
   input wire logic done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // A request counts only while idle
   wire logic tk = !busy && (table_read_instr || table_read_post_inc);
   chk_fetch_follows: assert property (tk |=> pm_rd) else $error("no fetch");
   chk_done_time: assert property (tk |-> ##2 done) else $error("done late");
   chk_busy_span: assert property (tk |=> busy [*2] ##1 !busy) else $error("busy span");
   chk_word_addr: assert property (pm_rd |-> pm_word_addr == table_byte_pointer[20:1]) else $error("addr");
   chk_byte_pick: assert property (done |-> table_latch == ($past(table_byte_pointer[0]) ?
      $past(pm_rd_data[15:8]) : $past(pm_rd_data[7:0]))) else $error("byte pick");
   chk_post_step: assert property (tk && table_read_post_inc |-> ##2
      table_byte_pointer == $past(table_byte_pointer, 2) + 21'h000001) else $error("step");
   chk_plain_keep: assert property (tk && !table_read_post_inc |-> ##2 $stable(table_byte_pointer))
      else $error("moved");
   chk_latch_hold: assert property (!done |-> $stable(table_latch)) else $error("latch moved");
endmodule : ptr_tr_monitor
bind ptr_table_read ptr_tr_monitor u_mon (.clk(clk), .nrst(nrst), .table_read_instr(table_read_instr),
   .table_read_post_inc(table_read_post_inc), .pm_word_addr(pm_word_addr), .pm_rd(pm_rd),
   .pm_rd_data(pm_rd_data), .table_byte_pointer(table_byte_pointer), .table_latch(table_latch),
   .busy(busy), .done(done));

// ===== bench/ptr_pm_model.sv
// Program memory array model
`timescale 1ns/1ps
module ptr_pm_model (
   input wire logic clk,
   input wire logic [19:0] pm_word_addr,
   input wire logic pm_rd,
   output logic [15:0] pm_rd_data
);
   logic rd_q;
   logic [15:0] w;
   always_ff @(posedge clk) rd_q <= pm_rd;
   // One word per address; inverted except during a fetch and the cycle after, so stale data never matches
   assign w = {pm_word_addr[15:8] ^ pm_word_addr[7:0], pm_word_addr[7:0]};
   assign pm_rd_data = (pm_rd || rd_q) ? w : ~w;
endmodule : ptr_pm_model

// ===== bench/ptr_table_read_tb_top.sv
// Self-checking bench for the table-read block
`timescale 1ns/1ps
module ptr_table_read_tb_top;
   logic clk = 0, nrst = 0, rd = 0, rdi = 0, wu = 0, wh = 0, wl = 0, pmr, bsy, dn;
   logic [7:0] wd = 8'h00, tl;
   logic [19:0] wa;
   logic [15:0] pd;
   logic [20:0] tp;
   int fails = 0, comparisons = 0, p = 0;
   always #5 clk = ~clk;
   ptr_table_read DUT (.clk(clk), .nrst(nrst), .table_read_instr(rdi), .table_read_post_inc(rd), .ptr_upper_wr(wu),
      .ptr_high_wr(wh), .ptr_low_wr(wl), .ptr_wr_data(wd), .pm_word_addr(wa), .pm_rd(pmr), .pm_rd_data(pd),
      .table_byte_pointer(tp), .table_latch(tl), .busy(bsy), .done(dn));
   ptr_pm_model u_pm (.clk(clk), .pm_word_addr(wa), .pm_rd(pmr), .pm_rd_data(pd));
   task automatic cmp(string n, logic [20:0] e, logic [20:0] s);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic load(logic [20:0] a);
      for (int i = 2; i >= 0; i--) begin
         @(posedge clk);
         {wu, wh, wl} <= 3'h1 << i;
         wd <= 8'(a >> (8 * i));
      end
      @(posedge clk);
      {wu, wh, wl} <= 3'h0;
      p = a;
      #1 cmp("pointer", a, tp);
   endtask : load
   // Extra read and pointer write land while busy and must be ignored
   task automatic rd_op(logic inc, logic extra);
      logic [15:0] w;
      w = {p[16:9] ^ p[8:1], p[8:1]};
      @(posedge clk);
      {rd, rdi} <= inc ? {1'b1, extra} : 2'h1;
      @(posedge clk);
      {rd, rdi} <= {extra, 1'b0};
      wl <= extra;
      wd <= 8'($urandom);
      #1 cmp("busy", 21'h1, 21'(bsy));
      cmp("fetch", 21'h1, 21'(pmr));
      cmp("word address", 21'(p[20:1]), 21'(wa));
      @(posedge clk);
      {rd, wl} <= 2'h0;
      #1 cmp("done", 21'h1, 21'(dn));
      cmp("latch", 21'(p[0] ? w[15:8] : w[7:0]), 21'(tl));
      p = (p + inc) & 21'h1FFFFF;
      cmp("pointer", 21'(p), tp);
   endtask : rd_op
   task automatic report_and_stop();
      $display("Counts: comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence: wrap at the top of program space, then random words
   initial begin
      void'($urandom(72));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      load(21'h1FFFFE);
      repeat (3) rd_op(1'b1, 1'b1);
      rd_op(1'b0, 1'b0);
      $display("Wrap test done");
      for (int i = 0; i < 20; i++) begin
         load(21'($urandom));
         rd_op(1'b1, 1'($urandom));
         rd_op(1'($urandom), 1'b0);
      end
      $display("Random test done");
      report_and_stop();
   end
   // Watchdog against a hang
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : ptr_table_read_tb_top
